// ---- inc/qsp_pkg.sv ----
package qsp_pkg;
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned WR_HOLD_US   = 200;
  localparam int unsigned RST_HOLD_MS  = 20;
  localparam int unsigned STARTUP_MS   = 50;
  localparam int unsigned PULSE_US     = 20;
  localparam int unsigned SETUP_US     = 5;
  localparam int unsigned WR_HOLD_CYC  = WR_HOLD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned STARTUP_CYC  = STARTUP_MS * (CLK_HZ / 1000);
  localparam int unsigned PULSE_CYC    = PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SETUP_CYC    = SETUP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FILT_CYC     = 1_100_000;
  localparam int unsigned FILT_HI      = 6;
  localparam int unsigned FILT_LO      = 2;
  localparam int unsigned FILT_LEN     = 8;
  localparam int unsigned STABLE_CYC   = 200_000;
  localparam int unsigned CNT_W        = 32;

  typedef struct packed {
    logic lead;
    logic lag;
  } qsp_phase_t;

  typedef struct packed {
    logic sel_n;
    logic strobe_n;
    logic dir;
  } qsp_out_t;

  typedef enum logic [2:0] {
    QSP_HOLD  = 3'b000,
    QSP_QUIET = 3'b001,
    QSP_IDLE  = 3'b011,
    QSP_SETUP = 3'b010,
    QSP_PULSE = 3'b110,
    QSP_WRITE = 3'b111,
    QSP_TAIL  = 3'b101
  } qsp_state_t;
endpackage : qsp_pkg

// ---- rtl/qsp_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module qsp_filter #(
  parameter int unsigned SAMPLE_CYC = qsp_pkg::FILT_CYC,
  parameter int unsigned STABLE     = qsp_pkg::STABLE_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic raw,
  output var  logic clean
);
  import qsp_pkg::*;

  logic [FILT_LEN-1:0] window;
  logic [CNT_W-1:0]    samp_cnt;
  logic [CNT_W-1:0]    stab_cnt;
  logic [3:0]          ones;
  logic                level;
  logic                tick;
  logic                next_level;

  // averaging window, then two-threshold compare
  always_comb begin
    ones = 4'h0;
    for (int i = 0; i < FILT_LEN; i++) begin
      ones = ones + {3'h0, window[i]};
    end
  end
  assign tick = (samp_cnt >= CNT_W'(SAMPLE_CYC / FILT_LEN));
  assign next_level = (ones >= 4'(FILT_HI)) ? 1'b1 :
                      (ones <= 4'(FILT_LO)) ? 1'b0 : level;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      window   <= '1;
      samp_cnt <= '0;
      stab_cnt <= '0;
      level    <= 1'b1;
      clean    <= 1'b1;
    end else begin
      samp_cnt <= tick ? '0 : samp_cnt + 1'b1;
      if (tick) begin
        window <= {window[FILT_LEN-2:0], raw};
        level  <= next_level;
      end
      // stability timer
      if (level == clean) begin
        stab_cnt <= '0;
      end else if (stab_cnt >= CNT_W'(STABLE)) begin
        clean    <= level;
        stab_cnt <= '0;
      end else begin
        stab_cnt <= stab_cnt + 1'b1;
      end
    end
  end
endmodule : qsp_filter
`default_nettype wire

// ---- rtl/qsp_step_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module qsp_step_gen #(
  parameter int unsigned RST_HOLD  = qsp_pkg::RST_HOLD_CYC,
  parameter int unsigned STARTUP   = qsp_pkg::STARTUP_CYC,
  parameter int unsigned WR_HOLD   = qsp_pkg::WR_HOLD_CYC,
  parameter int unsigned FILT_SAMP = qsp_pkg::FILT_CYC,
  parameter int unsigned STABLE    = qsp_pkg::STABLE_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire qsp_pkg::qsp_phase_t phase_raw,
  input  wire logic              wr_en,
  output var  qsp_pkg::qsp_out_t out,
  output var  logic              out_oe,
  output var  logic              busy
);
  import qsp_pkg::*;

  qsp_phase_t       ph;
  qsp_phase_t       ph_prev;
  qsp_state_t       state;
  logic [CNT_W-1:0] cnt;
  logic             wr_lat;
  logic [1:0]       last_src;
  logic             lead_chg;
  logic             lag_chg;
  logic             up_evt;
  logic             dn_evt;
  logic             step_req;
  logic             cnt_done;
  logic [CNT_W-1:0] limit;

  qsp_filter #(.SAMPLE_CYC(FILT_SAMP), .STABLE(STABLE)) u_flt_lead (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .raw     (phase_raw.lead),
    .clean   (ph.lead)
  );
  qsp_filter #(.SAMPLE_CYC(FILT_SAMP), .STABLE(STABLE)) u_flt_lag (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .raw     (phase_raw.lag),
    .clean   (ph.lag)
  );

  // last_src: 01 lead changed last, 10 lag changed last, 00 none
  assign lead_chg = ph.lead != ph_prev.lead;
  assign lag_chg  = ph.lag != ph_prev.lag;
  assign up_evt   = lag_chg && !lead_chg && last_src == 2'h1;
  assign dn_evt   = lead_chg && !lag_chg && last_src == 2'h2;
  assign step_req = up_evt || dn_evt;
  assign busy     = state inside {QSP_SETUP, QSP_PULSE, QSP_WRITE, QSP_TAIL};

  always_comb begin
    unique case (state)
      QSP_HOLD:  limit = CNT_W'(RST_HOLD);
      QSP_QUIET: limit = CNT_W'(STARTUP);
      QSP_SETUP: limit = CNT_W'(SETUP_CYC);
      // write sequence stretches the strobe to the write hold time
      QSP_PULSE: limit = wr_lat ? CNT_W'(WR_HOLD) : CNT_W'(PULSE_CYC);
      QSP_WRITE: limit = CNT_W'(WR_HOLD);
      QSP_TAIL:  limit = CNT_W'(SETUP_CYC);
      default:   limit = '0;
    endcase
  end
  assign cnt_done = (cnt >= limit - 1'b1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_prev  <= '1;
      last_src <= 2'h0;
    end else begin
      ph_prev <= ph;
      // a second change on the same phase keeps the same source: wiggle
      if (lead_chg && lag_chg) begin
        last_src <= 2'h0;
      end else if (up_evt || dn_evt) begin
        last_src <= 2'h0;
      end else if (lead_chg) begin
        last_src <= 2'h1;
      end else if (lag_chg) begin
        last_src <= 2'h2;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= QSP_HOLD;
      cnt    <= '0;
      out    <= '{sel_n: 1'b1, strobe_n: 1'b1, dir: 1'b1};
      out_oe <= 1'b0;
      wr_lat <= 1'b0;
    end else begin
      cnt <= cnt_done ? '0 : cnt + 1'b1;
      unique case (state)
        QSP_HOLD: if (cnt_done) begin
          state  <= QSP_QUIET;
          out_oe <= 1'b1;
        end
        QSP_QUIET: if (cnt_done) state <= QSP_IDLE;
        QSP_IDLE: begin
          cnt <= '0;
          if (step_req) begin
            out.dir <= up_evt;
            wr_lat  <= wr_en;
            state   <= QSP_SETUP;
          end
        end
        QSP_SETUP: if (cnt_done) begin
          out.sel_n    <= 1'b0;
          out.strobe_n <= 1'b0;
          state        <= QSP_PULSE;
        end
        QSP_PULSE: if (cnt_done) begin
          out.strobe_n <= 1'b1;
          state        <= wr_lat ? QSP_WRITE : QSP_TAIL;
        end
        QSP_WRITE: if (cnt_done) state <= QSP_TAIL;
        QSP_TAIL: if (cnt_done) begin
          out.sel_n <= 1'b1;
          state     <= QSP_IDLE;
        end
        default: state <= QSP_HOLD;
      endcase
    end
  end

  // checks
  sequence s_pulse_low;
    !out.sel_n && !out.strobe_n;
  endsequence
  a_idle_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == QSP_IDLE |-> out.sel_n && out.strobe_n)
    else $error("outputs not idle high");
  a_strobe_in_sel: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !out.strobe_n |-> !out.sel_n)
    else $error("strobe low outside select");
  a_dir_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !out.sel_n && !$past(out.sel_n) |-> $stable(out.dir))
    else $error("direction moved during select");
  a_dir_up: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == QSP_IDLE && up_evt |=> out.dir)
    else $error("up step without high direction");
  a_dir_down: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == QSP_IDLE && dn_evt |=> !out.dir)
    else $error("down step without low direction");
  a_no_wiggle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lead_chg && !lag_chg && last_src == 2'h1 |-> !step_req)
    else $error("step from single phase");
  a_hold_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state inside {QSP_HOLD, QSP_QUIET} |-> out.sel_n && !busy)
    else $error("activity during startup");
  a_hold_tristate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == QSP_HOLD |-> !out_oe)
    else $error("outputs driven during reset hold");
  a_write_tail: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pulse_low ##1 (out.strobe_n && wr_lat) |-> !out.sel_n[*8])
    else $error("select released too early on write");
  a_drop_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busy && step_req |=> $stable(out.dir) || !out.sel_n == $past(!out.sel_n))
    else $error("new step disturbed running pulse");
endmodule : qsp_step_gen
`default_nettype wire

// ---- sim/qsp_pot_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module qsp_pot_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        sel_n,
  input  wire logic        strobe_n,
  input  wire logic        dir,
  output var  logic [7:0]  wiper,
  output var  logic [15:0] sel_len,
  output var  logic [15:0] stb_len,
  output var  logic        dir_err
);
  logic        stb_q;
  logic        sel_q;
  logic        dir_q;
  logic [15:0] sel_cnt;
  logic [15:0] stb_cnt;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {stb_q, sel_q, dir_q} <= 3'h7;
      {wiper, sel_len, stb_len, sel_cnt, stb_cnt} <= '0;
      dir_err <= 1'b0;
    end else begin
      stb_q <= strobe_n;
      sel_q <= sel_n;
      dir_q <= dir;
      if (stb_q && !strobe_n && !sel_n)
        wiper <= dir ? wiper + 8'h01 : wiper - 8'h01;
      sel_cnt <= sel_n ? 16'h0000 : sel_cnt + 16'h0001;
      stb_cnt <= strobe_n ? 16'h0000 : stb_cnt + 16'h0001;
      if (sel_n && !sel_q)
        sel_len <= sel_cnt;
      if (strobe_n && !stb_q)
        stb_len <= stb_cnt;
      if (!sel_n && !sel_q && dir != dir_q)
        dir_err <= 1'b1;
    end
  end
endmodule : qsp_pot_model
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import qsp_pkg::*;
  localparam int WRH = 40;
  logic        sys_clk, rst_n, wr_en, busy, out_oe, dir_err;
  qsp_phase_t  ph;
  qsp_out_t    out, pin;
  logic [7:0]  wiper;
  logic [15:0] sel_len, stb_len, nsel;
  int          mismatches, cmp_count;
  // undriven pins float to the pull-up level
  assign pin = out_oe ? out : 3'h7;
  qsp_step_gen #(.RST_HOLD(20), .STARTUP(50), .WR_HOLD(WRH),
    .FILT_SAMP(16), .STABLE(4)) u_dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .phase_raw(ph), .wr_en(wr_en), .out(out),
    .out_oe(out_oe), .busy(busy));
  qsp_pot_model u_pot (.sys_clk(sys_clk), .rst_n(rst_n),
    .sel_n(pin.sel_n), .strobe_n(pin.strobe_n), .dir(pin.dir),
    .wiper(wiper), .sel_len(sel_len), .stb_len(stb_len),
    .dir_err(dir_err));
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic mv(logic [1:0] v);
    ph = v;
    tick(100);
  endtask : mv
  task automatic wait_idle();
    int i;
    for (i = 0; i < 9000 && busy !== 1'b0; i++)
      tick(1);
    if (i == 9000) begin
      mismatches++;
      test_done();
    end
    // let the pot model latch the closing pulse lengths
    tick(2);
  endtask : wait_idle
  task automatic t_reset();
    tick(10);
    chk("oe_hold", 1'b0, out_oe);
    tick(20);
    chk("oe_on", 1'b1, out_oe);
    chk("idle", 3'h7, out);
    tick(60);
    chk("no_step", 8'h00, wiper);
    $display("reset test done");
  endtask : t_reset
  task automatic t_up();
    mv(2'h1);
    mv(2'h0);
    chk("busy", 1'b1, busy);
    chk("dir_up", 1'b1, out.dir);
    wait_idle();
    chk("wiper1", 8'h01, wiper);
    nsel = sel_len;
    chk("sel_norm", 16'(PULSE_CYC + SETUP_CYC), nsel);
    mv(2'h2);
    mv(2'h3);
    wait_idle();
    chk("wiper2", 8'h02, wiper);
    $display("up test done");
  endtask : t_up
  task automatic t_down();
    mv(2'h2);
    mv(2'h0);
    chk("dir_dn", 1'b0, out.dir);
    wait_idle();
    chk("wiper_dn", 8'h01, wiper);
    $display("down test done");
  endtask : t_down
  task automatic t_wiggle();
    mv(2'h2);
    mv(2'h0);
    mv(2'h2);
    mv(2'h0);
    chk("wig_busy", 1'b0, busy);
    chk("wig_wiper", 8'h01, wiper);
    $display("wiggle test done");
  endtask : t_wiggle
  task automatic t_write();
    wr_en = 1'b1;
    mv(2'h2);
    mv(2'h3);
    wait_idle();
    wr_en = 1'b0;
    chk("wr_wiper", 8'h02, wiper);
    chk("stb_len", 16'(WRH), stb_len);
    chk("sel_extra", 16'(2 * WRH + SETUP_CYC), sel_len);
    chk("stb_first", 1'b1, sel_len > stb_len);
    $display("write test done");
  endtask : t_write
  task automatic t_busy();
    mv(2'h1);
    mv(2'h0);
    mv(2'h2);
    mv(2'h3);
    wait_idle();
    tick(300);
    chk("drop_busy", 1'b0, busy);
    chk("drop_wiper", 8'h03, wiper);
    chk("dir_hold", 1'b0, dir_err);
    $display("busy test done");
  endtask : t_busy
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    {mismatches, cmp_count} = '0;
    rst_n = 1'b0;
    wr_en = 1'b0;
    ph = 2'h3;
    nsel = '0;
    tick(2);
    rst_n = 1'b1;
    t_reset();
    t_up();
    t_down();
    t_wiggle();
    t_write();
    t_busy();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
